// >>> vtp_pkg.sv
package vtp_pkg;

  // Word index width of the register space
  localparam int unsigned IDX_W = 12;

  // Register word indices (byte address = 4 * index)
  localparam logic [IDX_W-1:0] IDX_PAT_CFG = 12'hC13;
  localparam logic [IDX_W-1:0] IDX_ECNT_HI = 12'hC16;
  localparam logic [IDX_W-1:0] IDX_ECNT_LO = 12'hC17;
  localparam logic [IDX_W-1:0] IDX_TXSZ_HI = 12'hC1A;
  localparam logic [IDX_W-1:0] IDX_TXSZ_LO = 12'hC1B;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'hC20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'hC21;

  // Error counter layout
  localparam int unsigned ECNT_W = 15;
  localparam logic [ECNT_W-1:0] ECNT_RST = 15'h0000;
  localparam logic [ECNT_W-1:0] ECNT_MAX = 15'h7FFF;
  localparam logic [ECNT_W-1:0] ECNT_ONE = 15'h0001;
  localparam logic [ECNT_W-1:0] ECNT_HI_MASK = 15'h7F00;
  localparam logic [ECNT_W-1:0] ECNT_LO_MASK = 15'h00FF;

  // Transmit size layout
  localparam int unsigned NGRP = 7;
  localparam int unsigned NGRP_LO = 4;
  localparam logic [5:0] TXSZ_HI_RST = 6'h3F;
  localparam logic [7:0] TXSZ_LO_RST = 8'hFF;
  localparam logic [1:0] SIZE_VC12 = 2'h2;

  // Interrupt status bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_LOCK_GAIN = 0;
  localparam int unsigned IRQ_LOCK_LOSS = 1;
  localparam int unsigned IRQ_CNT_SAT = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Expected pattern selection
  typedef enum logic [1:0] {
    PAT_ZEROS = 2'b00,
    PAT_ONES = 2'b01,
    PAT_ALT = 2'b10,
    PAT_PRBS = 2'b11
  } vtp_pat_t;

  // Pattern receiver states
  typedef enum logic [0:0] {
    ST_HUNT = 1'b0,
    ST_LOCK = 1'b1
  } vtp_rx_state_t;

  // Pattern receiver status
  typedef struct packed {
    logic lock;
    logic err;
  } vtp_pat_stat_t;

  // Transmit sizing per group
  typedef struct packed {
    logic [NGRP-1:0][1:0] grp;
  } vtp_tx_size_t;

endpackage

// >>> vtp_pat_rx.sv
`timescale 1ns/1ps
module vtp_pat_rx import vtp_pkg::*; #(
  parameter int unsigned SYNC_BITS = 16,
  parameter int unsigned LOSS_ERRS = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire vtp_pat_t mode_i,
  input wire logic bit_i,
  input wire logic bit_vld_i,
  output vtp_pat_stat_t stat_o
);

  if (SYNC_BITS < 2 || SYNC_BITS > 255 || LOSS_ERRS < 1 || LOSS_ERRS > 255) begin : g_chk
    $error("vtp_pat_rx: SYNC_BITS or LOSS_ERRS out of range");
  end

  vtp_rx_state_t state_reg, state_next;
  vtp_pat_t mode_reg, mode_next;
  logic [14:0] prbs_reg, prbs_next;
  logic alt_reg, alt_next;
  logic [7:0] run_reg, run_next;
  logic err_reg, err_next;
  logic exp_bit;
  logic miss;

  ////////////////////////////////////////////////////////////////
  // Expected bit per selected pattern
  always_comb begin
    case (mode_reg)
      PAT_ZEROS: exp_bit = 1'b0;
      PAT_ONES: exp_bit = 1'b1;
      PAT_ALT: exp_bit = alt_reg;
      PAT_PRBS: exp_bit = prbs_reg[14] ^ prbs_reg[13];
      default: exp_bit = 1'b0;
    endcase
    miss = bit_i ^ exp_bit;
  end

  ////////////////////////////////////////////////////////////////
  // Sync hunt, lock and error detection
  always_comb begin
    state_next = state_reg;
    mode_next = mode_i;
    prbs_next = prbs_reg;
    alt_next = alt_reg;
    run_next = run_reg;
    err_next = 1'b0;
    if (mode_i != mode_reg) begin
      // New pattern choice restarts the hunt
      state_next = ST_HUNT;
      run_next = 8'h00;
    end else if (bit_vld_i) begin
      // Hunting seeds generators from the line, lock runs them free
      prbs_next = {prbs_reg[13:0], (state_reg == ST_HUNT) ? bit_i : exp_bit};
      alt_next = ~((state_reg == ST_HUNT) ? bit_i : exp_bit);
      case (state_reg)
        ST_HUNT: begin
          if (miss) begin
            run_next = 8'h00;
          end else if (run_reg == 8'(SYNC_BITS - 1)) begin
            state_next = ST_LOCK;
            run_next = 8'h00;
          end else begin
            run_next = run_reg + 8'h01;
          end
        end
        ST_LOCK: begin
          err_next = miss;
          if (!miss) begin
            run_next = 8'h00;
          end else if (run_reg == 8'(LOSS_ERRS - 1)) begin
            state_next = ST_HUNT;
            run_next = 8'h00;
          end else begin
            run_next = run_reg + 8'h01;
          end
        end
        default: begin
          state_next = ST_HUNT;
          run_next = 8'h00;
        end
      endcase
    end
  end

  // Receiver state registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= ST_HUNT;
      mode_reg <= PAT_ZEROS;
      prbs_reg <= 15'h0000;
      alt_reg <= 1'b0;
      run_reg <= 8'h00;
      err_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      prbs_reg <= prbs_next;
      alt_reg <= alt_next;
      run_reg <= run_next;
      err_reg <= err_next;
    end
  end

  assign stat_o.lock = (state_reg == ST_LOCK);
  assign stat_o.err = err_reg;

  ////////////////////////////////////////////////////////////////
  // Checks
  property p_zero_err;
    @(posedge clk_i) disable iff (srst_i)
    (state_reg == ST_LOCK && mode_reg == PAT_ZEROS && mode_i == PAT_ZEROS && bit_vld_i && bit_i) |=> stat_o.err;
  endproperty
  a_zero_err: assert property (p_zero_err) else $error("missed all-zeros error");

  property p_err_only_locked;
    @(posedge clk_i) disable iff (srst_i)
    stat_o.err |-> $past(state_reg == ST_LOCK) && $past(bit_vld_i);
  endproperty
  a_err_only_locked: assert property (p_err_only_locked) else $error("error outside lock");

endmodule

// >>> vtp_top.sv
`timescale 1ns/1ps
// Contract
// - Upper count bit 7 shows pattern lock
// - 15-bit counter counts errors only while locked
// - Upper holds count 14:8, lower 7:0
// - Reading a count register clears its bits
// - Two-bit transmit size per group, 10 VC-12
// - Groups 6..4 upper register, 3..0 lower
// - Upper transmit bits 7:6 read zero
// - Transmit size drives transmit mapping only
// - Expected pattern: zeros, ones, 1010, PRBS15
module vtp_top import vtp_pkg::*; #(
  parameter int unsigned SYNC_BITS = 16,
  parameter int unsigned LOSS_ERRS = 4
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic test_bit_i,
  input wire logic test_bit_vld_i,
  output vtp_tx_size_t tx_size_o,
  output logic pattern_lock_flag_o,
  output logic irq_o
);

  if (SYNC_BITS < 2 || LOSS_ERRS < 1) begin : g_chk
    $error("vtp_top: SYNC_BITS or LOSS_ERRS out of range");
  end

  ////////////////////////////////////////////////////////////////
  // Declarations
  logic dph_vld_reg, dph_vld_next;
  logic dph_wr_reg, dph_wr_next;
  logic dph_hit_reg, dph_hit_next;
  logic [IDX_W-1:0] dph_idx_reg, dph_idx_next;
  logic rd_done_reg, rd_done_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic take;
  logic rd_fire;
  logic wr_fire;
  logic [7:0] rd_byte;

  vtp_pat_t pat_cfg_reg, pat_cfg_next;
  logic [5:0] txsz_hi_reg, txsz_hi_next;
  logic [7:0] txsz_lo_reg, txsz_lo_next;
  logic [ECNT_W-1:0] cnt_reg, cnt_next;
  logic [ECNT_W-1:0] cnt_base;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [IRQ_W-1:0] irq_mask_reg, irq_mask_next;
  logic [IRQ_W-1:0] irq_evt;
  logic lock_d_reg, lock_d_next;
  vtp_pat_stat_t pat_stat;

  ////////////////////////////////////////////////////////////////
  // Pattern receiver
  vtp_pat_rx #(
    .SYNC_BITS(SYNC_BITS),
    .LOSS_ERRS(LOSS_ERRS)
  ) u_pat_rx (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .mode_i(pat_cfg_reg),
    .bit_i(test_bit_i),
    .bit_vld_i(test_bit_vld_i),
    .stat_o(pat_stat)
  );

  ////////////////////////////////////////////////////////////////
  // AHB-Lite slave handshake
  assign take = hsel_i && (htrans_i == HTRANS_NONSEQ) && hready_i;
  assign rd_fire = dph_vld_reg && !dph_wr_reg && !rd_done_reg;
  assign wr_fire = dph_vld_reg && dph_wr_reg && dph_hit_reg;
  // Reads take one wait state so a preceding write is visible
  assign hreadyout_o = !rd_fire;
  assign hresp_o = HRESP_OKAY;
  assign hrdata_o = hrdata_reg;

  // Read data selection
  always_comb begin
    rd_byte = 8'h00;
    if (dph_hit_reg) begin
      case (dph_idx_reg)
        IDX_PAT_CFG: rd_byte = {pat_cfg_reg, 6'h00};
        IDX_ECNT_HI: rd_byte = {pat_stat.lock, cnt_reg[14:8]};
        IDX_ECNT_LO: rd_byte = cnt_reg[7:0];
        IDX_TXSZ_HI: rd_byte = {2'h0, txsz_hi_reg};
        IDX_TXSZ_LO: rd_byte = txsz_lo_reg;
        IDX_IRQ_STAT: rd_byte = {5'h00, irq_stat_reg};
        IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask_reg};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // Bus phase next state
  always_comb begin
    dph_vld_next = dph_vld_reg;
    dph_wr_next = dph_wr_reg;
    dph_hit_next = dph_hit_reg;
    dph_idx_next = dph_idx_reg;
    rd_done_next = rd_done_reg;
    hrdata_next = hrdata_reg;
    if (rd_fire) begin
      hrdata_next = {24'h000000, rd_byte};
      rd_done_next = 1'b1;
    end else begin
      dph_vld_next = take;
      dph_wr_next = hwrite_i;
      dph_hit_next = (haddr_i[31:IDX_W+2] == '0);
      dph_idx_next = haddr_i[IDX_W+1:2];
      rd_done_next = 1'b0;
    end
  end

  // Bus phase registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dph_vld_reg <= 1'b0;
      dph_wr_reg <= 1'b0;
      dph_hit_reg <= 1'b0;
      dph_idx_reg <= '0;
      rd_done_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
    end else begin
      dph_vld_reg <= dph_vld_next;
      dph_wr_reg <= dph_wr_next;
      dph_hit_reg <= dph_hit_next;
      dph_idx_reg <= dph_idx_next;
      rd_done_reg <= rd_done_next;
      hrdata_reg <= hrdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Configuration registers
  always_comb begin
    pat_cfg_next = pat_cfg_reg;
    txsz_hi_next = txsz_hi_reg;
    txsz_lo_next = txsz_lo_reg;
    irq_mask_next = irq_mask_reg;
    if (wr_fire) begin
      case (dph_idx_reg)
        IDX_PAT_CFG: pat_cfg_next = vtp_pat_t'(hwdata_i[7:6]);
        IDX_TXSZ_HI: txsz_hi_next = hwdata_i[5:0];
        IDX_TXSZ_LO: txsz_lo_next = hwdata_i[7:0];
        IDX_IRQ_MASK: irq_mask_next = hwdata_i[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Configuration storage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pat_cfg_reg <= PAT_ZEROS;
      txsz_hi_reg <= TXSZ_HI_RST;
      txsz_lo_reg <= TXSZ_LO_RST;
      irq_mask_reg <= IRQ_RST;
    end else begin
      pat_cfg_reg <= pat_cfg_next;
      txsz_hi_reg <= txsz_hi_next;
      txsz_lo_reg <= txsz_lo_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Per-group transmit sizing, transmit side only
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    if (g < NGRP_LO) begin : g_lo
      assign tx_size_o.grp[g] = txsz_lo_reg[2*g+1:2*g];
    end else begin : g_hi
      assign tx_size_o.grp[g] = txsz_hi_reg[2*(g-NGRP_LO)+1:2*(g-NGRP_LO)];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Error counter with clear on read
  always_comb begin
    cnt_base = cnt_reg;
    if (rd_fire && dph_hit_reg && dph_idx_reg == IDX_ECNT_HI) begin
      cnt_base = cnt_reg & ~ECNT_HI_MASK;
    end else if (rd_fire && dph_hit_reg && dph_idx_reg == IDX_ECNT_LO) begin
      cnt_base = cnt_reg & ~ECNT_LO_MASK;
    end
    cnt_next = cnt_base;
    // Clear applies first, then the increment; hold at all ones
    if (pat_stat.err && cnt_base != ECNT_MAX) begin
      cnt_next = cnt_base + ECNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt events and sticky status
  always_comb begin
    lock_d_next = pat_stat.lock;
    irq_evt = '0;
    irq_evt[IRQ_LOCK_GAIN] = pat_stat.lock && !lock_d_reg;
    irq_evt[IRQ_LOCK_LOSS] = !pat_stat.lock && lock_d_reg;
    irq_evt[IRQ_CNT_SAT] = pat_stat.err && cnt_base == ECNT_MAX;
    irq_stat_next = irq_stat_reg;
    if (rd_fire && dph_hit_reg && dph_idx_reg == IDX_IRQ_STAT) begin
      irq_stat_next = '0;
    end
    irq_stat_next = irq_stat_next | irq_evt;
  end

  // Counter and status storage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg <= ECNT_RST;
      irq_stat_reg <= IRQ_RST;
      lock_d_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      irq_stat_reg <= irq_stat_next;
      lock_d_reg <= lock_d_next;
    end
  end

  assign pattern_lock_flag_o = pat_stat.lock;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  property p_sync_bit;
    (rd_fire && dph_hit_reg && dph_idx_reg == IDX_ECNT_HI) |=> hrdata_o[7] == $past(pat_stat.lock);
  endproperty
  a_sync_bit: assert property (p_sync_bit) else $error("sync bit mismatch");

  property p_cnt_inc;
    (!rd_fire && pat_stat.err && cnt_reg != ECNT_MAX) |=> cnt_reg == $past(cnt_reg) + ECNT_ONE;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step");

  property p_cnt_hold;
    (!rd_fire && !pat_stat.err) |=> $stable(cnt_reg);
  endproperty
  a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without error");

  property p_lo_read;
    (rd_fire && dph_hit_reg && dph_idx_reg == IDX_ECNT_LO) |=> hrdata_o == {24'h000000, $past(cnt_reg[7:0])};
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("low count read wrong");

  property p_hi_clear;
    (rd_fire && dph_hit_reg && dph_idx_reg == IDX_ECNT_HI && !pat_stat.err) |=> cnt_reg[14:8] == 7'h00;
  endproperty
  a_hi_clear: assert property (p_hi_clear) else $error("upper count not cleared");

  property p_tx_lo_wr;
    (wr_fire && dph_idx_reg == IDX_TXSZ_LO) |=> tx_size_o.grp[0] == $past(hwdata_i[1:0])
      && tx_size_o.grp[3] == $past(hwdata_i[7:6]);
  endproperty
  a_tx_lo_wr: assert property (p_tx_lo_wr) else $error("low size field wrong");

  property p_tx_hi_wr;
    (wr_fire && dph_idx_reg == IDX_TXSZ_HI) |=> tx_size_o.grp[6] == $past(hwdata_i[5:4])
      && tx_size_o.grp[4] == $past(hwdata_i[1:0]);
  endproperty
  a_tx_hi_wr: assert property (p_tx_hi_wr) else $error("upper size field wrong");

  property p_resv_zero;
    (rd_fire && dph_hit_reg && dph_idx_reg == IDX_TXSZ_HI) |=> hrdata_o[7:6] == 2'h0;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bits not zero");

  property p_tx_isolated;
    (wr_fire && (dph_idx_reg == IDX_TXSZ_HI || dph_idx_reg == IDX_TXSZ_LO)) |=> $stable(pat_cfg_reg);
  endproperty
  a_tx_isolated: assert property (p_tx_isolated) else $error("size write touched other state");

  property p_saturate;
    (!rd_fire && cnt_reg == ECNT_MAX && pat_stat.err) |=> cnt_reg == ECNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("counter wrapped");

  property p_lo_clear;
    (rd_fire && dph_hit_reg && dph_idx_reg == IDX_ECNT_LO && !pat_stat.err) |=> cnt_reg[7:0] == 8'h00;
  endproperty
  a_lo_clear: assert property (p_lo_clear) else $error("lower count not cleared");

  property p_hi_keeps_lo;
    (rd_fire && dph_hit_reg && dph_idx_reg == IDX_ECNT_HI && !pat_stat.err) |=> cnt_reg[7:0] == $past(cnt_reg[7:0]);
  endproperty
  a_hi_keeps_lo: assert property (p_hi_keeps_lo) else $error("upper read touched lower count");

  // A read always sees exactly one wait state
  property p_read_wait;
    (take && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule

// >>> testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench import vtp_pkg::*;;
  logic clk_i;
  logic srst_i;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic tbit;
  logic tvld;
  vtp_tx_size_t tx_size;
  logic lock_flag;
  logic irq;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] rs = 32'd37;
  logic [14:0] ph;
  logic alt;
  logic [7:0] v;
  logic [7:0] w;
  int k;

  ////////////////////////////////////////////////////////////////////////////
  // Design under test
  vtp_top DUT (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .test_bit_i(tbit), .test_bit_vld_i(tvld),
    .tx_size_o(tx_size), .pattern_lock_flag_o(lock_flag), .irq_o(irq));

  // Clock, 25 ns period
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Xorshift source, fixed start
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  // Expected upper count view
  function automatic logic [7:0] hi_exp(input logic lk, input int c);
    logic [14:0] s;
    s = (c > 32767) ? 15'h7FFF : c[14:0];
    return {lk, s[14:8]};
  endfunction

  // One AHB single transfer, waits on hready
  task automatic bus(input logic [11:0] idx, input logic wr, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {18'h0, idx, 2'b00};
    hwrite <= wr;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    r = hrdata[7:0];
    `CHK(hresp, HRESP_OKAY)
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(idx, 1'b1, d, r);
  endtask

  task automatic rd(input logic [11:0] idx, output logic [7:0] r);
    bus(idx, 1'b0, 8'h00, r);
  endtask

  // One test bit, sometimes after a gap
  task automatic bit_tx(input logic b);
    if (rnd() % 5 == 0) begin
      @(posedge clk_i);
      tvld <= 1'b0;
    end
    @(posedge clk_i);
    tbit <= b;
    tvld <= 1'b1;
  endtask

  task automatic bit_idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      tvld <= 1'b0;
      tbit <= ~tbit;
    end
  endtask

  // Clean bits of the selected pattern
  task automatic feed(input logic [1:0] m, input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      case (m)
        2'h0: b = 1'b0;
        2'h1: b = 1'b1;
        2'h2: begin
          alt = ~alt;
          b = alt;
        end
        default: begin
          b = ph[13] ^ ph[14];
          ph = {ph[13:0], b};
        end
      endcase
      bit_tx(b);
    end
    bit_idle(4);
  endtask

  // Errors on a zeros pattern, never four in a row
  task automatic errs(input int n);
    for (int i = 0; i < n; i++) begin
      bit_tx(1'b1);
      bit_tx(1'b0);
    end
    bit_idle(4);
  endtask

  // Dense errors, three in a row then one match, no gaps
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (3) begin
        @(posedge clk_i);
        tbit <= 1'b1;
        tvld <= 1'b1;
      end
      @(posedge clk_i);
      tbit <= 1'b0;
    end
    bit_idle(4);
  endtask

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    srst_i = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tbit = 1'b0;
    tvld = 1'b0;
    alt = 1'b0;
    ph = rnd() | 15'h0001;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    // Reset values
    `CHK(tx_size, {NGRP{2'b11}})
    rd(IDX_TXSZ_HI, v); `CHK(v, 8'h3F)
    rd(IDX_TXSZ_LO, v); `CHK(v, 8'hFF)
    rd(IDX_ECNT_HI, v); `CHK(v, 8'h00)
    rd(IDX_ECNT_LO, v); `CHK(v, 8'h00)
    // Transmit sizing, random plus all-VC-12
    for (int i = 0; i < 6; i++) begin
      w = (i == 0) ? 8'hFF : (i == 5) ? 8'hEA : rnd();
      wr(IDX_TXSZ_HI, w);
      rd(IDX_TXSZ_HI, v); `CHK(v, w & 8'h3F)
      `CHK(tx_size.grp[6:4], w[5:0])
      w = (i == 5) ? 8'hAA : rnd();
      wr(IDX_TXSZ_LO, w);
      rd(IDX_TXSZ_LO, v); `CHK(v, w)
      `CHK(tx_size.grp[3:0], w)
    end
    `CHK(tx_size, {NGRP{SIZE_VC12}})
    // Unmapped place and read-only count
    rd(12'hC18, v); `CHK(v, 8'h00)
    wr(IDX_ECNT_LO, 8'h55);
    rd(IDX_ECNT_LO, v); `CHK(v, 8'h00)
    wr(IDX_IRQ_MASK, 8'h07);
    // Hunting: wrong bits neither lock nor count
    feed(2'h1, 40);
    `CHK(lock_flag, 1'b0)
    rd(IDX_ECNT_LO, v); `CHK(v, 8'h00)
    // Lock on zeros, interrupt on gain
    feed(2'h0, 20);
    `CHK(lock_flag, 1'b1)
    `CHK(irq, 1'b1)
    rd(IDX_IRQ_STAT, v); `CHK(v[0], 1'b1)
    `CHK(irq, 1'b0)
    // Random error burst, split over both registers
    k = 256 + (rnd() % 400);
    errs(k);
    rd(IDX_ECNT_LO, v); `CHK(v, k[7:0])
    rd(IDX_ECNT_HI, v); `CHK(v, hi_exp(1'b1, k))
    rd(IDX_ECNT_LO, v); `CHK(v, 8'h00)
    rd(IDX_ECNT_HI, v); `CHK(v, 8'h80)
    // Four errors in a row lose lock, all counted
    for (int i = 0; i < 4; i++) bit_tx(1'b1);
    bit_idle(4);
    `CHK(lock_flag, 1'b0)
    rd(IDX_ECNT_LO, v); `CHK(v, 8'h04)
    rd(IDX_ECNT_HI, v); `CHK(v, 8'h00)
    rd(IDX_IRQ_STAT, v); `CHK(v[1], 1'b1)
    // Each expected pattern, unmasked irq silent when masked
    wr(IDX_IRQ_MASK, 8'h00);
    for (int m = 1; m < 5; m++) begin
      wr(IDX_PAT_CFG, {m[1:0], 6'h00});
      rd(IDX_PAT_CFG, v); `CHK(v[7:6], m[1:0])
      feed(m[1:0], 40);
      `CHK(lock_flag, 1'b1)
      `CHK(irq, 1'b0)
      rd(IDX_IRQ_STAT, v);
    end
    // Saturation at all ones
    wr(IDX_IRQ_MASK, 8'h04);
    rd(IDX_ECNT_LO, v);
    rd(IDX_ECNT_HI, v);
    burst(10934);
    `CHK(irq, 1'b1)
    rd(IDX_ECNT_LO, v); `CHK(v, 8'hFF)
    rd(IDX_ECNT_HI, v); `CHK(v, hi_exp(1'b1, 32802))
    rd(IDX_IRQ_STAT, v); `CHK(v[2], 1'b1)
    conclude();
  end
endmodule
